//--- pkg/dma_cycle_pkg.sv
// Constants shared by the two-channel transfer sequencer.
// Assumes one clock domain, the bus clock.
package dma_cycle_pkg;
    // ==========================================================
    // Widths and channel count.
    localparam int ADDR_W = 20;
    localparam int CNT_W = 16;
    localparam int NCH = 2;
    // ==========================================================
    // Memory area codes of the source and destination.
    localparam logic [2:0] AREA_INT_NOWAIT = 3'h0;
    localparam logic [2:0] AREA_INT_WAIT = 3'h1;
    localparam logic [2:0] AREA_SFR_OSD = 3'h2;
    localparam logic [2:0] AREA_EXT_NOWAIT = 3'h3;
    localparam logic [2:0] AREA_EXT_WAIT = 3'h4;
    localparam logic [2:0] AREA_EXT_MUX = 3'h5;
    // ==========================================================
    // Area coefficients in bus cycles per access.
    localparam logic [1:0] COEF_PLAIN = 2'h1;
    localparam logic [1:0] COEF_WAIT = 2'h2;
    localparam logic [1:0] COEF_MUX = 2'h3;
    // ==========================================================
    // Accesses per phase, pointer steps and counter constants.
    localparam logic [1:0] ACC_ONE = 2'h1;
    localparam logic [1:0] ACC_TWO = 2'h2;
    localparam logic [19:0] STEP_BYTE = 20'h00001;
    localparam logic [19:0] STEP_WORD = 20'h00002;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
endpackage

//--- hdl/dma_cycle.sv
// Two-channel DMA transfer sequencer: cycle counts per unit and enable handling.
// Assumes the CPU gets the bus whenever bus_own is low; mclk is the bus clock.
//
// Functional notes
// - SFR, OSD RAM or software-wait areas add one bus cycle per access.
// - Write phase uses the same width, parity and wait conditions as read.
// - A 16-bit unit over an 8-bit bus takes two reads and two writes.
// - Any address parity is accepted; byte units take one read, one write.
// - 16-bit unit on 16-bit bus: one access if even, two if odd.
// - Unit cycles equal reads times source coefficient plus writes times destination coefficient.
// - Coefficients: internal 1, with wait 2, SFR/OSD 2, external 1/2, multiplexed 3.
// - Writing one to enable makes the channel active for requests.
// - First transfer after activation reloads forward pointer and transfer counter.
// - Writing one again while active restarts the channel from its initial state.
// - The 8-bit bus exists only in expansion modes; internal areas follow it then.
`timescale 1ns/1ns
`default_nettype none
module dma_cycle (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Mode and bus-width pin.
    input wire logic expansion_mode,
    input wire logic byte_pin,
    // Per-channel control bits.
    input wire logic [1:0] en_wr,
    input wire logic [1:0] en_wdata,
    input wire logic [1:0] repeat_mode,
    input wire logic [1:0] fwd_is_src,
    input wire logic [1:0] transfer_unit_size_select,
    input wire logic [1:0] dma_req,
    input wire logic [1:0][19:0] src_ptr,
    input wire logic [1:0][19:0] dst_ptr,
    input wire logic [1:0][15:0] cnt_reload,
    input wire logic [1:0][2:0] src_area,
    input wire logic [1:0][2:0] dst_area,
    // Channel status.
    output logic [1:0] chan_active,
    output logic [1:0][15:0] chan_count,
    // Shared memory bus.
    output logic bus_own,
    output logic bus_rd,
    output logic bus_wr,
    output logic [19:0] bus_addr,
    output logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata
);
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP} state_e;

    // ==========================================================
    // Coefficient per area.
    function automatic logic [1:0] area_coef(input logic [2:0] area);
        logic [1:0] c;
        c = dma_cycle_pkg::COEF_PLAIN;
        case (area)
            dma_cycle_pkg::AREA_INT_WAIT: c = dma_cycle_pkg::COEF_WAIT;
            dma_cycle_pkg::AREA_SFR_OSD: c = dma_cycle_pkg::COEF_WAIT;
            dma_cycle_pkg::AREA_EXT_WAIT: c = dma_cycle_pkg::COEF_WAIT;
            dma_cycle_pkg::AREA_EXT_MUX: c = dma_cycle_pkg::COEF_MUX;
            default: c = dma_cycle_pkg::COEF_PLAIN;
        endcase
        return c;
    endfunction

    // ==========================================================
    // Pin synchroniser for the bus-width pin.
    logic byte_s1_q;
    logic byte_s2_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            byte_s1_q <= 1'b0;
            byte_s2_q <= 1'b0;
        end else begin
            byte_s1_q <= byte_pin;
            byte_s2_q <= byte_s1_q;
        end
    end
    // The narrow bus is only meaningful outside single-chip mode.
    wire narrow_bus = expansion_mode & byte_s2_q;

    // ==========================================================
    // Engine state.
    state_e st_q;
    logic ch_q;
    logic beat_q;
    logic [1:0] clk_q;
    logic [1:0] nrd_q;
    logic [1:0] nwr_q;
    logic [1:0] jc_q;
    logic [1:0] kc_q;
    logic [19:0] sadr_q;
    logic [19:0] dadr_q;
    logic [15:0] data_q;
    logic size16_q;

    logic [1:0] active_q;
    logic [1:0] first_q;
    logic [1:0] pend_q;
    logic [1:0][15:0] cnt_q;
    logic [1:0][19:0] fwd_q;

    // ==========================================================
    // Start selection; channel 0 wins a tie.
    wire [1:0] ready_ch = active_q & pend_q;
    wire start = (st_q == ST_IDLE) && (ready_ch != 2'h0);
    wire sel_ch = ~ready_ch[0];
    wire sel_first = first_q[sel_ch];
    wire sel_w16 = ~transfer_unit_size_select[sel_ch];
    wire [19:0] sel_fwd = fwd_is_src[sel_ch] ? src_ptr[sel_ch] : dst_ptr[sel_ch];
    wire [19:0] sel_fwd_cur = sel_first ? sel_fwd : fwd_q[sel_ch];
    wire [19:0] sel_src = fwd_is_src[sel_ch] ? sel_fwd_cur : src_ptr[sel_ch];
    wire [19:0] sel_dst = fwd_is_src[sel_ch] ? dst_ptr[sel_ch] : sel_fwd_cur;
    // Each phase is judged on its own address and area.
    wire [1:0] sel_nrd = (sel_w16 && (narrow_bus || sel_src[0])) ?
        dma_cycle_pkg::ACC_TWO : dma_cycle_pkg::ACC_ONE;
    wire [1:0] sel_nwr = (sel_w16 && (narrow_bus || sel_dst[0])) ?
        dma_cycle_pkg::ACC_TWO : dma_cycle_pkg::ACC_ONE;

    wire acc_last = (clk_q == dma_cycle_pkg::COEF_PLAIN);
    wire rd_done = (st_q == ST_READ) && acc_last && (beat_q == (nrd_q == dma_cycle_pkg::ACC_TWO));
    wire wr_done = (st_q == ST_WRITE) && acc_last && (beat_q == (nwr_q == dma_cycle_pkg::ACC_TWO));
    wire unit_end = wr_done;
    wire two_beat = (st_q == ST_READ) ? (nrd_q == dma_cycle_pkg::ACC_TWO) : (nwr_q == dma_cycle_pkg::ACC_TWO);
    wire [19:0] step = size16_q ? dma_cycle_pkg::STEP_WORD : dma_cycle_pkg::STEP_BYTE;

    // ==========================================================
    // Sequencer: every access lasts its area coefficient in clocks.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            ch_q <= 1'b0;
            beat_q <= 1'b0;
            clk_q <= dma_cycle_pkg::COEF_PLAIN;
            nrd_q <= dma_cycle_pkg::ACC_ONE;
            nwr_q <= dma_cycle_pkg::ACC_ONE;
            jc_q <= dma_cycle_pkg::COEF_PLAIN;
            kc_q <= dma_cycle_pkg::COEF_PLAIN;
            sadr_q <= 20'h00000;
            dadr_q <= 20'h00000;
            data_q <= 16'h0000;
            size16_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        st_q <= ST_READ;
                        ch_q <= sel_ch;
                        beat_q <= 1'b0;
                        nrd_q <= sel_nrd;
                        nwr_q <= sel_nwr;
                        jc_q <= area_coef(src_area[sel_ch]);
                        kc_q <= area_coef(dst_area[sel_ch]);
                        clk_q <= area_coef(src_area[sel_ch]);
                        sadr_q <= sel_src;
                        dadr_q <= sel_dst;
                        size16_q <= sel_w16;
                    end
                end
                ST_READ, ST_WRITE: begin
                    if (!acc_last) begin
                        clk_q <= clk_q - 2'h1;
                    end else begin
                        if (st_q == ST_READ) begin
                            if (!two_beat) begin
                                data_q <= bus_rdata;
                            end else if (!beat_q) begin
                                data_q[7:0] <= bus_rdata[7:0];
                            end else begin
                                data_q[15:8] <= bus_rdata[7:0];
                            end
                        end
                        if (rd_done) begin
                            st_q <= ST_WRITE;
                            beat_q <= 1'b0;
                            clk_q <= kc_q;
                        end else if (wr_done) begin
                            st_q <= ST_GAP;
                        end else begin
                            beat_q <= 1'b1;
                            clk_q <= (st_q == ST_READ) ? jc_q : kc_q;
                        end
                    end
                end
                ST_GAP: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Per-channel enable, pending request, counter and forward pointer.
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            wire go = start && (sel_ch == g);
            wire fin = unit_end && (ch_q == g);
            wire underflow = fin && (cnt_q[g] == dma_cycle_pkg::CNT_ZERO);
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    active_q[g] <= 1'b0;
                    first_q[g] <= 1'b0;
                    pend_q[g] <= 1'b0;
                    cnt_q[g] <= 16'h0000;
                    fwd_q[g] <= 20'h00000;
                end else begin
                    // A request arriving as a transfer starts is kept.
                    pend_q[g] <= dma_req[g] | (pend_q[g] & ~go);
                    if (go && first_q[g]) begin
                        cnt_q[g] <= cnt_reload[g];
                        fwd_q[g] <= sel_fwd;
                    end else if (fin) begin
                        cnt_q[g] <= underflow ? cnt_reload[g] : cnt_q[g] - dma_cycle_pkg::CNT_ONE;
                        fwd_q[g] <= fwd_q[g] + step;
                    end
                    if (go) begin
                        first_q[g] <= 1'b0;
                    end
                    if (underflow && !repeat_mode[g]) begin
                        active_q[g] <= 1'b0;
                    end
                    // A write of one always wins and restarts the channel.
                    if (en_wr[g]) begin
                        active_q[g] <= en_wdata[g];
                        first_q[g] <= en_wdata[g];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Bus drive and status.
    assign bus_own = (st_q == ST_READ) || (st_q == ST_WRITE);
    assign bus_rd = (st_q == ST_READ);
    assign bus_wr = (st_q == ST_WRITE);
    assign bus_addr = (st_q == ST_WRITE) ? dadr_q + {19'h00000, beat_q} : sadr_q + {19'h00000, beat_q};
    assign bus_wdata = (beat_q || (nwr_q == dma_cycle_pkg::ACC_TWO && !beat_q)) ?
        (beat_q ? {8'h00, data_q[15:8]} : {8'h00, data_q[7:0]}) : data_q;
    assign chan_active = active_q;
    assign chan_count = cnt_q;

    // ==========================================================
    // Checks.
    logic [3:0] unit_clks_q;
    always_ff @(posedge mclk) begin
        if (!resetn || start) begin
            unit_clks_q <= 4'h0;
        end else if (bus_own) begin
            unit_clks_q <= unit_clks_q + 4'h1;
        end
    end
    wire [3:0] unit_expect = {2'h0, nrd_q} * {2'h0, jc_q} + {2'h0, nwr_q} * {2'h0, kc_q};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_UNIT_TOTAL: assert property (unit_end |-> unit_clks_q + 4'h1 == unit_expect)
        else $error("Unit length differs from reads times j plus writes times k.");
    AST_SFR_WAIT: assert property (start && src_area[sel_ch] == dma_cycle_pkg::AREA_SFR_OSD
        |=> bus_rd [*2])
        else $error("SFR source access not stretched by one bus cycle.");
    AST_MUX_COEF: assert property (start && dst_area[sel_ch] == dma_cycle_pkg::AREA_EXT_MUX |=> kc_q == 2'h3)
        else $error("Multiplexed bus coefficient is not three.");
    AST_NARROW_WORD: assert property (start && sel_w16 && narrow_bus |=> nrd_q == 2'h2 && nwr_q == 2'h2)
        else $error("Word over narrow bus must take two reads and two writes.");
    AST_BYTE_UNIT: assert property (start && !sel_w16 |=> nrd_q == 2'h1 && nwr_q == 2'h1)
        else $error("Byte unit must take one read and one write.");
    AST_WIDE_PARITY: assert property (start && sel_w16 && !narrow_bus
        |=> nrd_q == (sadr_q[0] ? 2'h2 : 2'h1))
        else $error("Wide-bus word read count does not follow source parity.");
    AST_DST_PARITY: assert property (start && sel_w16 && !narrow_bus
        |=> nwr_q == (dadr_q[0] ? 2'h2 : 2'h1))
        else $error("Write count does not follow destination parity.");
    AST_NO_NARROW_SINGLE: assert property (!expansion_mode && start |=> !(size16_q && nrd_q == 2'h2 && !sadr_q[0]))
        else $error("Narrow bus used in single-chip mode.");
    AST_ENABLE: assert property (en_wr[0] && en_wdata[0] |=> chan_active[0] && first_q[0])
        else $error("Enable write of one did not activate and restart channel 0.");
    AST_RELOAD: assert property (start && sel_first && sel_ch == 1'b0 && !en_wr[0]
        |=> chan_count[0] == $past(cnt_reload[0]))
        else $error("Transfer counter not reloaded at first transfer.");
    AST_GAP: assert property (unit_end |=> !bus_own ##1 !bus_own)
        else $error("Bus not returned to the CPU between units.");

    // ==========================================================
    // Sequencing, pointer and enable checks.
    AST_NO_LEAD: assert property (start |=> bus_rd)
        else $error("Read phase did not follow the start at once.");
    AST_RD_TO_WR: assert property (rd_done |=> bus_wr)
        else $error("Write phase did not follow the read phase at once.");
    AST_MUX_SRC: assert property (start && src_area[sel_ch] == dma_cycle_pkg::AREA_EXT_MUX
        |=> bus_rd [*3])
        else $error("Multiplexed source access not three bus cycles long.");
    AST_DST_WAIT: assert property (rd_done && kc_q == dma_cycle_pkg::COEF_WAIT |=> bus_wr [*2])
        else $error("Waited destination access not stretched by one bus cycle.");
    // Only channel 0 is checked here, since both channels share one pointer selection path.
    AST_FWD_LOAD: assert property (start && sel_first && sel_ch == 1'b0
        |=> fwd_q[0] == ($past(fwd_is_src[0]) ? $past(src_ptr[0]) : $past(dst_ptr[0])))
        else $error("Forward pointer not loaded at first transfer.");
    AST_ENABLE_CH1: assert property (en_wr[1] && en_wdata[1] |=> chan_active[1] && first_q[1])
        else $error("Enable write of one did not activate and restart channel 1.");
endmodule
`default_nettype wire

//--- bench/mem_model.sv
// Memory seen by the transfer sequencer over the shared bus.
// Assumes bus_rd qualifies bus_addr and that data is taken at the clock edge.
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    // Clock.
    input wire logic mclk,
    // Bus from the sequencer.
    input wire logic bus_rd,
    input wire logic [19:0] bus_addr,
    output logic [15:0] bus_rdata
);
    // ==========================================================
    // Read data.
    logic [15:0] last_q = 16'hFFFF;
    logic [15:0] word_d;
    assign word_d = {bus_addr[7:0] ^ 8'h5A, bus_addr[7:0]};
    always @(posedge mclk) begin
        if (bus_rd) begin
            last_q <= word_d;
        end
    end
    // A released bus shows the inverse of its last value, so stale data can never pass for a read.
    assign bus_rdata = bus_rd ? word_d : ~last_q;
endmodule
`default_nettype wire

//--- bench/tb_dma_cycle.sv
// Self-checking bench for the two-channel transfer sequencer.
// Assumes the sequencer and the memory model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_dma_cycle;
    logic mclk, resetn, expansion_mode, byte_pin;
    logic [1:0] en_wr, en_wdata, repeat_mode, fwd_is_src, transfer_unit_size_select, dma_req, chan_active;
    logic [1:0][19:0] src_ptr, dst_ptr;
    logic [1:0][15:0] cnt_reload, chan_count;
    logic [1:0][2:0] src_area, dst_area;
    logic bus_own, bus_rd, bus_wr;
    logic [19:0] bus_addr;
    logic [15:0] bus_wdata, bus_rdata, last_wd;
    int err_count = 0;
    int n_compared = 0;
    int coef [6] = '{1, 2, 2, 1, 2, 3};
    dma_cycle dma_cycle_i (.mclk(mclk), .resetn(resetn), .expansion_mode(expansion_mode), .byte_pin(byte_pin),
        .en_wr(en_wr), .en_wdata(en_wdata), .repeat_mode(repeat_mode), .fwd_is_src(fwd_is_src),
        .transfer_unit_size_select(transfer_unit_size_select), .dma_req(dma_req), .src_ptr(src_ptr),
        .dst_ptr(dst_ptr), .cnt_reload(cnt_reload), .src_area(src_area), .dst_area(dst_area),
        .chan_active(chan_active), .chan_count(chan_count), .bus_own(bus_own), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
    mem_model mem_model_i (.mclk(mclk), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_rdata(bus_rdata));
    // ==========================================================
    // Compare and closing tasks.
    task chk_num(input int got, input int exp, input string what);
        n_compared++;
        if (got != exp) begin
            err_count++;
            $display("BAD %0t %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    task chk_vec(input logic [19:0] got, input logic [19:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // Channel set-up and one transfer unit.
    task enable(input int ch);
        @(negedge mclk);
        en_wr[ch] = 1'b1;
        en_wdata[ch] = 1'b1;
        @(negedge mclk);
        en_wr[ch] = 1'b0;
    endtask
    task setup(input int ch, input logic sz, input logic rpt, input logic fwd, input logic [15:0] rl,
               input logic [19:0] s, input logic [19:0] d, input logic [2:0] sa, input logic [2:0] da);
        @(negedge mclk);
        transfer_unit_size_select[ch] = sz;
        repeat_mode[ch] = rpt;
        fwd_is_src[ch] = fwd;
        cnt_reload[ch] = rl;
        src_ptr[ch] = s;
        dst_ptr[ch] = d;
        src_area[ch] = sa;
        dst_area[ch] = da;
        enable(ch);
    endtask
    // Counts read and write cycles of one unit and the cycles the bus is held.
    task unit(input int ch, input int nr, input int nw, input logic [19:0] ea, input logic [19:0] eb);
        int t;
        int r;
        int w;
        int o;
        logic [19:0] ar;
        logic [19:0] aw;
        t = 0;
        r = 0;
        w = 0;
        o = 0;
        ar = 20'h00000;
        aw = 20'h00000;
        @(negedge mclk);
        dma_req[ch] = 1'b1;
        @(negedge mclk);
        dma_req[ch] = 1'b0;
        while (bus_own !== 1'b1 && t < 20) begin
            @(negedge mclk);
            t++;
        end
        while (bus_own === 1'b1 && o < 60) begin
            if (bus_rd === 1'b1) begin
                if (r == 0) ar = bus_addr;
                r++;
            end
            if (bus_wr === 1'b1) begin
                if (w == 0) begin
                    aw = bus_addr;
                    last_wd = bus_wdata;
                end
                w++;
            end
            o++;
            @(negedge mclk);
        end
        chk_num(r, nr, "read cycles");
        chk_num(w, nw, "write cycles");
        chk_num(o, nr + nw, "bus held cycles");
        chk_vec(ar, ea, "read address");
        chk_vec(aw, eb, "write address");
    endtask
    // ==========================================================
    // Scenarios.
    task t_forward;
        setup(0, 1'b1, 1'b1, 1'b1, 16'h0005, 20'h00101, 20'h00200, 3'h0, 3'h0);
        chk_vec({19'h00000, chan_active[0]}, 20'h00001, "active after enable");
        unit(0, 1, 1, 20'h00101, 20'h00200);
        // The counter loads as a first unit starts and steps, or reloads from zero, as every unit ends.
        chk_vec({4'h0, chan_count[0]}, 20'h00004, "count loaded");
        unit(0, 1, 1, 20'h00102, 20'h00200);
        chk_vec({4'h0, chan_count[0]}, 20'h00003, "count stepped");
        enable(0);
        unit(0, 1, 1, 20'h00101, 20'h00200);
        chk_vec({4'h0, chan_count[0]}, 20'h00004, "count reloaded");
        $display("test forward done");
    endtask
    task t_parity;
        setup(0, 1'b0, 1'b1, 1'b1, 16'h0005, 20'h00400, 20'h00600, 3'h0, 3'h0);
        unit(0, 1, 1, 20'h00400, 20'h00600);
        chk_vec({4'h0, last_wd}, 20'h05A00, "word data");
        setup(0, 1'b0, 1'b1, 1'b1, 16'h0005, 20'h00401, 20'h00603, 3'h0, 3'h0);
        unit(0, 2, 2, 20'h00401, 20'h00603);
        chk_vec({4'h0, last_wd}, 20'h00001, "low byte first");
        $display("test parity done");
    endtask
    task t_narrow;
        @(negedge mclk);
        expansion_mode = 1'b1;
        byte_pin = 1'b1;
        repeat (4) @(negedge mclk);
        setup(0, 1'b0, 1'b1, 1'b1, 16'h0005, 20'h00400, 20'h00600, 3'h0, 3'h0);
        unit(0, 2, 2, 20'h00400, 20'h00600);
        setup(0, 1'b1, 1'b1, 1'b1, 16'h0005, 20'h00401, 20'h00600, 3'h2, 3'h0);
        unit(0, 2, 1, 20'h00401, 20'h00600);
        expansion_mode = 1'b0;
        setup(0, 1'b0, 1'b1, 1'b1, 16'h0005, 20'h00400, 20'h00600, 3'h0, 3'h0);
        unit(0, 1, 1, 20'h00400, 20'h00600);
        byte_pin = 1'b0;
        repeat (4) @(negedge mclk);
        $display("test narrow done");
    endtask
    task t_area;
        for (int a = 0; a < 6; a++) begin
            setup(0, 1'b0, 1'b1, 1'b1, 16'h0005, 20'h00800, 20'h00A00, a[2:0], 3'(5 - a));
            unit(0, coef[a], coef[5 - a], 20'h00800, 20'h00A00);
        end
        setup(0, 1'b0, 1'b1, 1'b1, 16'h0005, 20'h00801, 20'h00A01, dma_cycle_pkg::AREA_SFR_OSD,
              dma_cycle_pkg::AREA_EXT_MUX);
        unit(0, 4, 6, 20'h00801, 20'h00A01);
        $display("test area done");
    endtask
    task t_single;
        setup(1, 1'b1, 1'b0, 1'b0, 16'h0001, 20'h00300, 20'h00500, 3'h0, 3'h0);
        unit(1, 1, 1, 20'h00300, 20'h00500);
        unit(1, 1, 1, 20'h00300, 20'h00501);
        chk_vec({19'h00000, chan_active[1]}, 20'h00000, "single mode ends");
        $display("test single done");
    endtask
    // ==========================================================
    // Clock, watchdog and main sequence.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        #1000000;
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        finish_test;
    end
    initial begin
        {resetn, expansion_mode, byte_pin, en_wr, en_wdata, repeat_mode, fwd_is_src} = '0;
        {transfer_unit_size_select, dma_req, src_ptr, dst_ptr, cnt_reload, src_area, dst_area} = '0;
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        t_forward;
        t_parity;
        t_narrow;
        t_area;
        t_single;
        finish_test;
    end
endmodule
`default_nettype wire
